/* File: src/page_table_walk_fill.sv */
// Translation-miss fill engine: address check, linear lookup and two-level walk.
//
// What this block does
// - Check every non-superpage miss address is a sign-extended 32-bit longword.
// - Raise a general exception for a noncanonical non-superpage miss; superpage misses fill from the low bits.
// - Linear lookup: zap upper bytes, entry at table base plus four times page number.
// - Walk: directory entry physically at directory base plus four times directory index.
// - Second level: directory frame shifted by page exponent plus four times table index.
// - Table-index exponent equals log2 of page size divided by four.
// - Directory base register holds physical address of current process's directory page.
// - Two-level walk is used whenever the linear lookup cannot complete.
// - Directory entries decode with the same field layout as mapping entries.
// - Granularity hint may map aligned blocks of eight to the N pages; optional.
// - Shared hint may make the cached translation global for all spaces.
// - Store to a page whose written flag is zero faults.
// - User mode needs the user-permit flag; kernel may access any valid page.
// - A cleared translation-ok flag raises a translation-not-valid fault.
// - Spare and reserved entry bits never affect translation or protection.
// - Instruction translation invalidation also invalidates instruction cache blocks.
// - Prevent duplicate buffer writes unless the buffer tolerates them.
// - Optionally special-case the self-map entry address in the second-level fill.
// - Entries are found purely by table position; no tag is stored.
// - On swap with non-negative frame number, load directory base from it.
// - Invalid first- or second-level entry during the walk raises not-valid fault.
`default_nettype none
module page_table_walk_fill
	import page_walk_pkg::*;
#(
	parameter int PAGE_SHIFT              = PAGE_SHIFT_DEF,
	parameter bit HONOR_GRANULARITY       = 1'b1,
	parameter bit HONOR_GLOBAL            = 1'b1,
	parameter bit TB_TOLERATES_DUP        = 1'b0,
	parameter bit SELF_MAP_SHORTCUT       = 1'b1,
	parameter bit ICACHE_PHYS_NONCOHERENT = 1'b1
)(
	input  wire logic                          core_clk,
	input  wire logic                          srst,
	input  wire logic                          miss_valid,
	input  wire logic [VA_IN_W-1:0]            miss_va,
	input  wire logic                          miss_store,
	input  wire logic                          miss_ifetch,
	input  wire logic                          miss_user,
	input  wire logic                          force_phys_walk,
	output logic                               miss_ready,
	input  wire logic                          swap_valid,
	input  wire logic [PFN_W:0]                swap_pfn,
	output logic [PFN_W+PAGE_SHIFT-1:0]        directory_base_reg,
	output logic                               mem_req_valid,
	output logic [PFN_W+PAGE_SHIFT-1:0]        mem_req_addr,
	output logic                               mem_req_phys,
	input  wire logic                          mem_req_ready,
	input  wire logic                          mem_rsp_valid,
	input  wire logic [31:0]                   mem_rsp_data,
	input  wire logic                          mem_rsp_fault,
	output logic                               fill_valid,
	output logic                               fill_tb_wr,
	output logic                               fill_ifetch,
	output logic [VA_W-PAGE_SHIFT-1:0]         fill_vpn,
	output logic [PFN_W-1:0]                   fill_pfn,
	output logic [1:0]                         fill_granularity_hint,
	output logic                               fill_global,
	output logic                               fill_write_ok,
	output logic                               fill_user_ok,
	output logic                               fault_valid,
	output logic [1:0]                         fault_code,
	output logic [VA_IN_W-1:0]                 fault_va,
	output logic                               fault_store,
	input  wire logic                          tb_inval_valid,
	input  wire logic                          tb_inval_istream,
	input  wire logic [PFN_W-1:0]              tb_inval_pfn,
	output logic                               icache_inval_valid,
	output logic [PFN_W-1:0]                   icache_inval_pfn
);

	localparam int PA_W      = PFN_W + PAGE_SHIFT;
	localparam int VPN_W     = VA_W - PAGE_SHIFT;
	localparam int PTI_SHIFT = PAGE_SHIFT - ENTRY_LOG2;
	localparam int PDE_SHIFT = PAGE_SHIFT + PTI_SHIFT;

	// Refuse page sizes the address arithmetic cannot serve.
	generate
		if (PAGE_SHIFT < PAGE_SHIFT_MIN || PAGE_SHIFT > PAGE_SHIFT_MAX)
		begin : g_bad_page_shift
			$error("page_table_walk_fill: PAGE_SHIFT out of range");
		end
	endgenerate

	// A canonical longword has bits 63..32 all equal to bit 31.
	function automatic logic is_canonical(input logic [VA_IN_W-1:0] va);
		is_canonical = (va[VA_IN_W-1:VA_W] == {(VA_IN_W-VA_W){va[VA_W-1]}});
	endfunction

	// The large superpage sits at the very top of the 64-bit space.
	function automatic logic is_superpage(input logic [VA_IN_W-1:0] va);
		is_superpage = &va[VA_IN_W-1:SUPERPAGE_LO];
	endfunction

	walk_state_type    state_q;
	walk_state_type    state_d;
	logic [VA_W-1:0]   va_q;
	logic [VA_IN_W-1:0] full_va_q;
	logic              store_q;
	logic              ifetch_q;
	logic              user_q;
	logic [PA_W-1:0]   dir_base_q;
	logic              req_valid_q;
	logic [PA_W-1:0]   req_addr_q;
	logic              req_phys_q;
	logic              hist_valid_q;
	logic [VPN_W-1:0]  hist_vpn_q;

	logic [PFN_W-1:0]  dec_pfn;
	logic [1:0]        dec_gran;
	logic              dec_global;
	logic              dec_write_fault;
	logic              dec_user;
	logic              dec_ok;

	logic [VA_W-1:0]   va_w;
	logic [VA_W-1:0]   pte_va;
	logic [PA_W-1:0]   pde_pa;
	logic [PA_W-1:0]   pte_pa;
	logic [PA_W-1:0]   self_map_entry_pa;
	logic              addr_bad;
	logic              take_miss;
	logic              self_hit;
	logic              finish_now;
	logic              start_req;
	logic [PA_W-1:0]   start_addr;
	logic              start_phys;
	logic              dup_block;

	// Both directory and mapping entries come back on the same bus.
	pte_field_decode u_decode
	(
		.entry            (mem_rsp_data),
		.pfn              (dec_pfn),
		.granularity_hint (dec_gran),
		.global_hint      (dec_global),
		.write_fault_flag (dec_write_fault),
		.user_permit      (dec_user),
		.translation_ok   (dec_ok)
	);

	// Address arithmetic; an entry's address is its table position only.
	always_comb
	begin
		va_w   = state_q[ST_IDLE_BIT] ? miss_va[VA_W-1:0] : va_q;
		pte_va = VIRTUAL_PTE_BASE + ((va_w >> PAGE_SHIFT) << ENTRY_LOG2);
		pde_pa = dir_base_q + (PA_W'(va_w >> PDE_SHIFT) << ENTRY_LOG2);
		pte_pa = (PA_W'(dec_pfn) << PAGE_SHIFT)
			+ (PA_W'(va_w[PDE_SHIFT-1:PAGE_SHIFT]) << ENTRY_LOG2);
		self_map_entry_pa = dir_base_q
			+ (PA_W'(VIRTUAL_PTE_BASE >> PDE_SHIFT) << ENTRY_LOG2);
	end

	// Miss acceptance and walk decisions.
	always_comb
	begin
		addr_bad  = !is_canonical(miss_va) && !is_superpage(miss_va);
		take_miss = state_q[ST_IDLE_BIT] && miss_valid;
		self_hit  = SELF_MAP_SHORTCUT && (pte_pa == self_map_entry_pa);
		finish_now = mem_rsp_valid && (
			(state_q == ST_VLOAD && !mem_rsp_fault) ||
			(state_q == ST_PDLOAD && (!dec_ok || self_hit)) ||
			(state_q == ST_PTLOAD));
		dup_block = !TB_TOLERATES_DUP && hist_valid_q
			&& (hist_vpn_q == va_q[VA_W-1:PAGE_SHIFT]);
	end

	// Next state of the walk sequencer.
	always_comb
	begin
		state_d = state_q;
		case (state_q)
			ST_IDLE:
			begin
				if (miss_valid && !addr_bad)
				begin
					state_d = force_phys_walk ? ST_PDLOAD : ST_VLOAD;
				end
			end
			ST_VLOAD:
			begin
				if (mem_rsp_valid)
				begin
					state_d = mem_rsp_fault ? ST_PDLOAD : ST_IDLE;
				end
			end
			ST_PDLOAD:
			begin
				if (mem_rsp_valid)
				begin
					state_d = (!dec_ok || self_hit) ? ST_IDLE : ST_PTLOAD;
				end
			end
			ST_PTLOAD:
			begin
				if (mem_rsp_valid)
				begin
					state_d = ST_IDLE;
				end
			end
			default:
			begin
				state_d = ST_IDLE;
			end
		endcase
	end

	// Memory request to launch, if any, this cycle.
	always_comb
	begin
		start_req  = 1'b0;
		start_addr = '0;
		start_phys = 1'b0;
		if (take_miss && !addr_bad)
		begin
			start_req  = 1'b1;
			start_phys = force_phys_walk;
			start_addr = force_phys_walk ? pde_pa : PA_W'(pte_va);
		end
		else if (state_q == ST_VLOAD && mem_rsp_valid && mem_rsp_fault)
		begin
			start_req  = 1'b1;
			start_phys = 1'b1;
			start_addr = pde_pa;
		end
		else if (state_q == ST_PDLOAD && mem_rsp_valid && dec_ok && !self_hit)
		begin
			start_req  = 1'b1;
			start_phys = 1'b1;
			start_addr = pte_pa;
		end
	end

	// Sequencer state register.
	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			state_q <= ST_IDLE;
		end
		else
		begin
			state_q <= state_d;
		end
	end

	// Capture of the miss being served.
	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			va_q      <= '0;
			full_va_q <= '0;
			store_q   <= 1'b0;
			ifetch_q  <= 1'b0;
			user_q    <= 1'b0;
		end
		else if (take_miss)
		begin
			va_q      <= miss_va[VA_W-1:0];  // Upper bytes zapped.
			full_va_q <= miss_va;
			store_q   <= miss_store;
			ifetch_q  <= miss_ifetch;
			user_q    <= miss_user;
		end
	end

	// Memory request, held until the memory system accepts it.
	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			req_valid_q <= 1'b0;
			req_addr_q  <= '0;
			req_phys_q  <= 1'b0;
		end
		else if (start_req)
		begin
			req_valid_q <= 1'b1;
			req_addr_q  <= start_addr;
			req_phys_q  <= start_phys;
		end
		else if (mem_req_ready)
		begin
			req_valid_q <= 1'b0;
		end
	end

	// Directory base, reloaded per process on an address space swap.
	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			dir_base_q <= '0;
		end
		else if (swap_valid && !swap_pfn[PFN_W])
		begin
			dir_base_q <= PA_W'(swap_pfn[PFN_W-1:0]) << PAGE_SHIFT;
		end
	end

	// Answers to the core: a fill or a fault, one-cycle pulses.
	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			fill_valid            <= 1'b0;
			fill_tb_wr            <= 1'b0;
			fill_ifetch           <= 1'b0;
			fill_vpn              <= '0;
			fill_pfn              <= '0;
			fill_granularity_hint <= 2'h0;
			fill_global           <= 1'b0;
			fill_write_ok         <= 1'b0;
			fill_user_ok          <= 1'b0;
			fault_valid           <= 1'b0;
			fault_code            <= FAULT_GENERAL;
			fault_va              <= '0;
			fault_store           <= 1'b0;
		end
		else
		begin
			fill_valid  <= 1'b0;
			fill_tb_wr  <= 1'b0;
			fault_valid <= 1'b0;
			if (take_miss && addr_bad)
			begin
				fault_valid <= 1'b1;
				fault_code  <= FAULT_GENERAL;
				fault_va    <= miss_va;
				fault_store <= miss_store;
			end
			else if (finish_now)
			begin
				fault_va    <= full_va_q;
				fault_store <= store_q;
				if (!dec_ok)
				begin
					fault_valid <= 1'b1;
					fault_code  <= FAULT_NOT_VALID;
				end
				else if (user_q && !dec_user)
				begin
					fault_valid <= 1'b1;
					fault_code  <= FAULT_ACCESS;
				end
				else if (store_q && dec_write_fault)
				begin
					fault_valid <= 1'b1;
					fault_code  <= FAULT_ON_WRITE;
				end
				else
				begin
					fill_valid            <= 1'b1;
					fill_tb_wr            <= !dup_block;
					fill_ifetch           <= ifetch_q;
					fill_vpn              <= va_q[VA_W-1:PAGE_SHIFT];
					fill_pfn              <= dec_pfn;
					fill_granularity_hint <= HONOR_GRANULARITY ? dec_gran : 2'h0;
					fill_global           <= HONOR_GLOBAL && dec_global;
					fill_write_ok         <= !dec_write_fault;
					fill_user_ok          <= dec_user;
				end
			end
		end
	end

	// History of the last buffer write; any invalidate forgets it.
	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			hist_valid_q <= 1'b0;
			hist_vpn_q   <= '0;
		end
		else if (tb_inval_valid)
		begin
			hist_valid_q <= 1'b0;
		end
		else if (finish_now && dec_ok && !fault_pending(user_q, dec_user, store_q,
			dec_write_fault))
		begin
			hist_valid_q <= 1'b1;
			hist_vpn_q   <= va_q[VA_W-1:PAGE_SHIFT];
		end
	end

	// Protection check used by the history path; the answer path repeats it inline.
	function automatic logic fault_pending(input logic user, input logic permit,
		input logic store, input logic wfault);
		fault_pending = (user && !permit) || (store && wfault);
	endfunction

	// Instruction cache blocks follow an invalidated instruction translation.
	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			icache_inval_valid <= 1'b0;
			icache_inval_pfn   <= '0;
		end
		else
		begin
			icache_inval_valid <= ICACHE_PHYS_NONCOHERENT && tb_inval_valid
				&& tb_inval_istream;
			if (tb_inval_valid && tb_inval_istream)
			begin
				icache_inval_pfn <= tb_inval_pfn;
			end
		end
	end

	assign miss_ready         = state_q[ST_IDLE_BIT];
	assign directory_base_reg = dir_base_q;
	assign mem_req_valid      = req_valid_q;
	assign mem_req_addr       = req_addr_q;
	assign mem_req_phys       = req_phys_q;

endmodule : page_table_walk_fill
`default_nettype wire

/* File: src/page_walk_pkg.sv */
// Constants and types shared by the translation-miss fill engine.
`default_nettype none
package page_walk_pkg;

	// Address widths and page geometry.
	localparam int VA_IN_W        = 64;
	localparam int VA_W           = 32;
	localparam int PAGE_SHIFT_DEF = 13;
	localparam int PAGE_SHIFT_MIN = 10;
	localparam int PAGE_SHIFT_MAX = 16;
	localparam int ENTRY_LOG2     = 2;
	localparam int SUPERPAGE_LO   = 42;

	// Base of the linear page table in the mapped page-table space.
	localparam logic [31:0] VIRTUAL_PTE_BASE = 32'hC000_0000;

	// Entry field positions; the same layout serves directory entries.
	localparam int ENT_VALID_BIT   = 0;
	localparam int ENT_OWNER_BIT   = 1;
	localparam int ENT_DIRTY_BIT   = 2;
	localparam int ENT_RSVD_BIT    = 3;
	localparam int ENT_GLOBAL_BIT  = 4;
	localparam int ENT_GRAN_LO     = 5;
	localparam int ENT_GRAN_HI     = 6;
	localparam int ENT_SPARE_LO    = 7;
	localparam int ENT_SPARE_HI    = 8;
	localparam int ENT_PFN_LO      = 9;
	localparam int ENT_PFN_HI      = 31;
	localparam int PFN_W           = ENT_PFN_HI - ENT_PFN_LO + 1;

	// Fault classes reported to the core.
	localparam logic [1:0] FAULT_GENERAL   = 2'h0;
	localparam logic [1:0] FAULT_NOT_VALID = 2'h1;
	localparam logic [1:0] FAULT_ACCESS    = 2'h2;
	localparam logic [1:0] FAULT_ON_WRITE  = 2'h3;

	// Walk sequencer states, one-hot.
	typedef enum logic [3:0]
	{
		ST_IDLE   = 4'h1,
		ST_VLOAD  = 4'h2,
		ST_PDLOAD = 4'h4,
		ST_PTLOAD = 4'h8
	} walk_state_type;
	localparam int ST_IDLE_BIT = 0;

endpackage : page_walk_pkg
`default_nettype wire

/* File: src/pte_field_decode.sv */
// Field decoder for page table and page directory entries.
`default_nettype none
module pte_field_decode
	import page_walk_pkg::*;
(
	input  wire logic [31:0]      entry,
	output logic      [PFN_W-1:0] pfn,
	output logic      [1:0]       granularity_hint,
	output logic                  global_hint,
	output logic                  write_fault_flag,
	output logic                  user_permit,
	output logic                  translation_ok
);

	// Software-spare and reserved bits are simply never looked at.
	assign pfn              = entry[ENT_PFN_HI:ENT_PFN_LO];
	assign granularity_hint = entry[ENT_GRAN_HI:ENT_GRAN_LO];
	assign global_hint      = entry[ENT_GLOBAL_BIT];
	assign write_fault_flag = ~entry[ENT_DIRTY_BIT];  // Written flag inverted.
	assign user_permit      = entry[ENT_OWNER_BIT];
	assign translation_ok   = entry[ENT_VALID_BIT];

endmodule : pte_field_decode
`default_nettype wire

/* File: tb/page_table_walk_fill_asserts.sv */
// Concurrent checks on the ports of the translation-miss fill engine.
`default_nettype none
module page_table_walk_fill_asserts
	import page_walk_pkg::*;
#(
	parameter int PAGE_SHIFT = PAGE_SHIFT_DEF
)(
	input wire logic                       core_clk,
	input wire logic                       srst,
	input wire logic                       miss_valid,
	input wire logic [VA_IN_W-1:0]         miss_va,
	input wire logic                       force_phys_walk,
	input wire logic                       miss_ready,
	input wire logic                       swap_valid,
	input wire logic [PFN_W:0]             swap_pfn,
	input wire logic [PFN_W+PAGE_SHIFT-1:0] directory_base_reg,
	input wire logic                       mem_req_valid,
	input wire logic [PFN_W+PAGE_SHIFT-1:0] mem_req_addr,
	input wire logic                       mem_req_phys,
	input wire logic                       mem_req_ready,
	input wire logic                       fill_valid,
	input wire logic [VA_W-PAGE_SHIFT-1:0] fill_vpn,
	input wire logic                       fault_valid,
	input wire logic [1:0]                 fault_code,
	input wire logic [VA_IN_W-1:0]         fault_va,
	input wire logic                       tb_inval_valid,
	input wire logic                       tb_inval_istream,
	input wire logic [PFN_W-1:0]           tb_inval_pfn,
	input wire logic                       icache_inval_valid,
	input wire logic [PFN_W-1:0]           icache_inval_pfn
);
	localparam int PA_W   = PFN_W + PAGE_SHIFT;
	localparam int PDE_SH = 2 * PAGE_SHIFT - ENTRY_LOG2;
	logic [VA_IN_W-1:0] va_q;
	logic               canon;

	// Holds the address of the miss being served, since answers come later.
	always_ff @(posedge core_clk)
	begin
		if (miss_valid && miss_ready)
			va_q <= miss_va;
	end

	// Sign-extended longword, or a large superpage address.
	assign canon = (miss_va[63:32] == {32{miss_va[31]}}) || (&miss_va[VA_IN_W-1:SUPERPAGE_LO]);

	default clocking @(posedge core_clk); endclocking
	default disable iff (srst);

	sequence take_s;
		miss_valid && miss_ready;
	endsequence
	sequence linear_req_s;
		mem_req_valid && !mem_req_phys
			&& mem_req_addr == PA_W'(VIRTUAL_PTE_BASE + {va_q[31:PAGE_SHIFT], 2'h0});
	endsequence
	sequence dir_req_s;
		mem_req_valid && mem_req_phys
			&& mem_req_addr == directory_base_reg + PA_W'({va_q[31:PDE_SH], 2'h0});
	endsequence

	noncanon_fault_a: assert property (
		take_s ##0 !canon |=> fault_valid && fault_code == FAULT_GENERAL && fault_va == va_q
			&& !mem_req_valid) else $error("bad address not refused");
	linear_req_a: assert property (
		take_s ##0 canon && !force_phys_walk |=> linear_req_s) else $error("linear load wrong");
	phys_walk_a: assert property (
		take_s ##0 canon && force_phys_walk |=> dir_req_s) else $error("directory load wrong");
	req_hold_a: assert property (
		mem_req_valid && !mem_req_ready |=> mem_req_valid && $stable(mem_req_addr)
			&& $stable(mem_req_phys)) else $error("memory request dropped");
	one_miss_a: assert property (
		mem_req_valid |-> !miss_ready) else $error("ready while walking");
	single_answer_a: assert property (
		fill_valid || fault_valid |-> miss_ready && !(fill_valid && fault_valid))
		else $error("answer not single");
	swap_load_a: assert property (
		swap_valid && !swap_pfn[PFN_W] |=> directory_base_reg
			== PA_W'($past(swap_pfn[PFN_W-1:0])) << PAGE_SHIFT) else $error("swap not loaded");
	swap_keep_a: assert property (
		swap_valid && swap_pfn[PFN_W] |=> $stable(directory_base_reg))
		else $error("negative swap changed base");
	icache_inval_a: assert property (
		tb_inval_valid && tb_inval_istream |=> icache_inval_valid
			&& icache_inval_pfn == $past(tb_inval_pfn)) else $error("no icache invalidate");
	fill_vpn_a: assert property (
		fill_valid |-> fill_vpn == va_q[VA_W-1:PAGE_SHIFT]) else $error("fill page wrong");
	fault_addr_a: assert property (
		fault_valid |-> fault_va == va_q) else $error("fault address wrong");
endmodule // page_table_walk_fill_asserts
`default_nettype wire

/* File: tb/page_walk_mem_model.sv */
// Memory system model answering virtual and physical entry loads.
`default_nettype none
module page_walk_mem_model
#(
	parameter int PA_W = 36
)(
	input wire logic            core_clk,
	input wire logic            srst,
	input wire logic            slow,
	input wire logic            mem_req_valid,
	input wire logic [PA_W-1:0] mem_req_addr,
	input wire logic            mem_req_phys,
	output logic                mem_req_ready,
	output logic                mem_rsp_valid,
	output logic [31:0]         mem_rsp_data,
	output logic                mem_rsp_fault
);
	logic [31:0]     pm [logic [PA_W-1:0]];
	logic [31:0]     vm [logic [PA_W-1:0]];
	logic [PA_W-1:0] addr_q;
	logic            phys_q;
	logic [1:0]      wait_q;
	logic            tick_q;

	// A slow memory accepts only every other cycle; one load is outstanding.
	assign mem_req_ready = (wait_q == 2'h0) && (!slow || tick_q);

	// Answers after one or three cycles; idle data toggles so it is never stale.
	always_ff @(posedge core_clk)
	begin
		tick_q <= !srst && !tick_q;  // Reset keeps the slow acceptance pattern defined.
		mem_rsp_valid <= 1'h0;
		mem_rsp_fault <= 1'h0;
		mem_rsp_data <= ~mem_rsp_data;
		if (srst)
			wait_q <= 2'h0;
		else if (wait_q != 2'h0)
		begin
			wait_q <= wait_q - 2'h1;
			if (wait_q == 2'h1)
			begin
				mem_rsp_valid <= 1'h1;
				// Entries are found by address alone; absent ones read as zero.
				if (phys_q)
					mem_rsp_data <= pm.exists(addr_q) ? pm[addr_q] : 32'h0;
				else
					mem_rsp_data <= vm.exists(addr_q) ? vm[addr_q] : 32'h0;
				mem_rsp_fault <= !phys_q && !vm.exists(addr_q);
			end
		end
		else if (mem_req_valid && mem_req_ready)
		begin
			addr_q <= mem_req_addr;
			phys_q <= mem_req_phys;
			wait_q <= slow ? 2'h3 : 2'h1;
		end
	end
endmodule // page_walk_mem_model
`default_nettype wire

/* File: tb/page_table_walk_fill_bench.sv */
// Self-checking bench for the translation-miss fill engine.
`default_nettype none
module page_table_walk_fill_bench
	import page_walk_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int PA_W = PFN_W + PAGE_SHIFT_DEF;
	logic core_clk, srst, miss_valid, miss_store, miss_ifetch, miss_user, force_phys_walk;
	logic miss_ready, swap_valid, mem_req_valid, mem_req_phys, mem_req_ready, mem_rsp_valid;
	logic mem_rsp_fault, fill_valid, fill_tb_wr, fill_ifetch, fill_global, fill_write_ok;
	logic fill_user_ok, fault_valid, fault_store, tb_inval_valid, tb_inval_istream, slow;
	logic icache_inval_valid, got_fill, got_fault, got_wr;
	logic [VA_IN_W-1:0]  miss_va, fault_va;
	logic [PFN_W:0]      swap_pfn;
	logic [PA_W-1:0]     directory_base_reg, mem_req_addr;
	logic [31:0]         mem_rsp_data;
	logic [VA_W-PAGE_SHIFT_DEF-1:0] fill_vpn;
	logic [PFN_W-1:0]    fill_pfn, tb_inval_pfn, icache_inval_pfn;
	logic [1:0]          fill_granularity_hint, fault_code;
	int                  num_errors, n_checks;

	page_table_walk_fill page_table_walk_fill_i (.core_clk, .srst, .miss_valid, .miss_va,
		.miss_store, .miss_ifetch, .miss_user, .force_phys_walk, .miss_ready, .swap_valid,
		.swap_pfn, .directory_base_reg, .mem_req_valid, .mem_req_addr, .mem_req_phys,
		.mem_req_ready, .mem_rsp_valid, .mem_rsp_data, .mem_rsp_fault, .fill_valid, .fill_tb_wr,
		.fill_ifetch, .fill_vpn, .fill_pfn, .fill_granularity_hint, .fill_global, .fill_write_ok,
		.fill_user_ok, .fault_valid, .fault_code, .fault_va, .fault_store, .tb_inval_valid,
		.tb_inval_istream, .tb_inval_pfn, .icache_inval_valid, .icache_inval_pfn);
	page_walk_mem_model #(.PA_W(PA_W)) mem_i (.core_clk, .srst, .slow, .mem_req_valid,
		.mem_req_addr, .mem_req_phys, .mem_req_ready, .mem_rsp_valid, .mem_rsp_data,
		.mem_rsp_fault);

	// Free-running clock, 4 ns period.
	initial
	begin
		core_clk = 1'h0;
		forever #2 core_clk = ~core_clk;
	end

	// Counts a comparison and reports a difference.
	task automatic chk(input logic [95:0] seen, input logic [95:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic end_sim();
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// Offers one miss and waits, bounded, for its fill or fault pulse.
	task automatic miss(input logic [63:0] va, input logic st, input logic us, input logic fw);
		int i;
		miss_va = va;
		miss_store = st;
		miss_user = us;
		force_phys_walk = fw;
		miss_valid = 1'h1;
		@(negedge core_clk);
		miss_valid = 1'h0;
		for (i = 0; i < 60; i++)
		begin
			if (fill_valid === 1'h1 || fault_valid === 1'h1)
				break;
			@(negedge core_clk);
		end
		if (i == 60)
		begin
			num_errors++;
			end_sim();
		end
		got_fill = fill_valid;
		got_fault = fault_valid;
		got_wr = fill_tb_wr;
		@(negedge core_clk);
	endtask

	// Pulses a swap with the given sign and frame number.
	task automatic swap(input logic [PFN_W:0] pfn);
		swap_pfn = pfn;
		swap_valid = 1'h1;
		@(negedge core_clk);
		swap_valid = 1'h0;
		@(negedge core_clk);
	endtask

	// Main sequence: reset, swap, linear fills, walks and faults.
	initial
	begin
		{srst, miss_valid, miss_store, miss_ifetch, miss_user, force_phys_walk} = 6'h20;
		{swap_valid, tb_inval_valid, tb_inval_istream, slow} = 4'h0;
		{miss_va, swap_pfn, tb_inval_pfn} = '0;
		num_errors = 0;
		n_checks = 0;
		repeat (5) @(negedge core_clk);
		srst = 1'h0;
		chk({miss_ready, directory_base_reg}, {1'h1, 36'h0});
		swap(24'h000100);
		chk(directory_base_reg, 36'h000200000);
		swap(24'h800500);
		chk(directory_base_reg, 36'h000200000);
		mem_i.vm[36'h0C0000008] = 32'h000247DF;
		miss(64'h4000, 1'h1, 1'h1, 1'h0);
		chk({got_fill, got_wr, fill_vpn}, {2'h3, 19'h00002});
		chk({fill_pfn, fill_granularity_hint, fill_global, fill_write_ok, fill_user_ok},
			{23'h000123, 2'h2, 3'h7});
		miss(64'h4000, 1'h0, 1'h0, 1'h0);
		chk({got_fill, got_wr}, 2'h2);
		tb_inval_pfn = 23'h000123;
		tb_inval_valid = 1'h1;
		tb_inval_istream = 1'h1;
		@(negedge core_clk);
		tb_inval_valid = 1'h0;
		chk({icache_inval_valid, icache_inval_pfn}, {1'h1, 23'h000123});
		miss(64'h4000, 1'h0, 1'h0, 1'h0);
		chk({got_fill, got_wr}, 2'h3);
		miss(64'h00000001_00004000, 1'h0, 1'h0, 1'h0);
		chk({got_fault, fault_code, fault_va}, {1'h1, FAULT_GENERAL, 64'h100004000});
		miss(64'hFFFF0000_00004000, 1'h1, 1'h0, 1'h0);
		chk({got_fault, fault_code, fault_store}, {1'h1, FAULT_GENERAL, 1'h1});
		miss_ifetch = 1'h1;
		miss(64'hFFFFFC00_00004000, 1'h0, 1'h0, 1'h0);
		chk({got_fill, fill_pfn, fill_ifetch}, {1'h1, 23'h000123, 1'h1});
		miss_ifetch = 1'h0;
		slow = 1'h1;
		mem_i.pm[36'h000200308] = 32'h00040001;
		mem_i.pm[36'h00040000C] = 32'h00AA0001;
		miss(64'hFFFFFFFF_C2006000, 1'h0, 1'h0, 1'h0);
		chk({got_fill, fill_pfn, fill_user_ok, fill_write_ok}, {1'h1, 23'h005500, 2'h0});
		chk(fill_ifetch, 1'h0);
		miss(64'hFFFFFFFF_C2006000, 1'h0, 1'h1, 1'h0);
		chk({got_fault, fault_code, fault_va}, {1'h1, FAULT_ACCESS, 64'hFFFFFFFFC2006000});
		miss(64'hFFFFFFFF_C2006000, 1'h1, 1'h0, 1'h0);
		chk({got_fault, fault_code, fault_store}, {1'h1, FAULT_ON_WRITE, 1'h1});
		mem_i.pm[36'h00040000C] = 32'h00AA0006;
		miss(64'hFFFFFFFF_C2006000, 1'h0, 1'h0, 1'h0);
		chk({got_fault, fault_code}, {1'h1, FAULT_NOT_VALID});
		slow = 1'h0;
		miss(64'h05000000, 1'h0, 1'h0, 1'h0);
		chk({got_fault, fault_code}, {1'h1, FAULT_NOT_VALID});
		mem_i.pm[36'h000200000] = 32'h00060001;
		mem_i.pm[36'h000600008] = 32'h000EE007;
		miss(64'h4000, 1'h1, 1'h1, 1'h1);
		chk({got_fill, fill_pfn, fill_user_ok}, {1'h1, 23'h000770, 1'h1});
		end_sim();
	end
endmodule // page_table_walk_fill_bench

bind page_table_walk_fill page_table_walk_fill_asserts #(.PAGE_SHIFT(PAGE_SHIFT)) asserts_i (
	.core_clk, .srst, .miss_valid, .miss_va, .force_phys_walk, .miss_ready, .swap_valid,
	.swap_pfn, .directory_base_reg, .mem_req_valid, .mem_req_addr, .mem_req_phys,
	.mem_req_ready, .fill_valid, .fill_vpn, .fault_valid, .fault_code, .fault_va,
	.tb_inval_valid, .tb_inval_istream, .tb_inval_pfn, .icache_inval_valid, .icache_inval_pfn);
`default_nettype wire
